/* File: dv/charge_device_model.sv */
// Purpose: portable device on the downstream ports
// Assumes: powered is the logical power state, polarity already undone
// Notes: pulls DP up only on divider or alternate levels; slow waits longer
`timescale 1ns/1ps
module charge_device_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bench control
  input wire logic [3:0] attached,
  input wire logic slow,
  input wire logic vdat_en,
  // hub side
  input wire logic [3:0] powered,
  input wire logic [3:0] divider_seen,
  input wire logic [3:0] dcp_seen,
  output logic [3:0] dp_pullup_seen,
  output logic [3:0] data_detect_voltage_seen
);
  logic [3:0][3:0] wait_reg;
  // settle count restarts whenever power drops or the device is unplugged
  always_ff @(posedge clock)
  begin
    for (int i = 0; i < 4; i++)
      if (rst || !powered[i] || !attached[i])
        wait_reg[i] <= 4'h0;
      else if (wait_reg[i] != 4'hF)
        wait_reg[i] <= wait_reg[i] + 4'h1;
  end
  // detector levels fall back to idle when unpowered or detached
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      dp_pullup_seen[i] = wait_reg[i] > (slow ? 4'h8 : 4'h1) && divider_seen[i];
      data_detect_voltage_seen[i] = wait_reg[i] > 4'h1 && dcp_seen[i] && vdat_en;
    end
  end
endmodule // charge_device_model

/* File: dv/hub_charge_checker.sv */
// Purpose: concurrent checks on the charging and power control ports
// Assumes: one clock domain, rst synchronous active high
// Notes: gap and divider-hold sequencing is watched on port 0 only; divider exit on upstream vbus is checked on all ports
`timescale 1ns/1ps
module hub_charge_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // watched inputs
  input wire logic cfg_wr,
  input wire logic serial_mode_sel_n,
  input wire logic upstream_vbus,
  input wire logic upstream_superspeed,
  input wire logic upstream_high_speed,
  input wire logic [3:0] dp_pullup_seen,
  // watched outputs
  input wire logic [3:0] low_divider_mode,
  input wire logic [3:0] high_divider_mode,
  input wire logic [3:0] cdp_mode,
  input wire logic [3:0] dcp_mode,
  input wire logic [3:0] alt_mode,
  input wire logic smbus_slave_mode,
  input wire logic ds_superspeed_disable,
  input wire logic ds_high_speed_disable
);
  logic [1:0] live_reg;
  logic sel_reg;
  logic excl;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // cycles since reset release, and the serial select strap on the first one
  always_ff @(posedge clock)
  begin
    if (rst)
      live_reg <= 2'h0;
    else if (live_reg != 2'h3)
      live_reg <= live_reg + 2'h1;
    if (!rst && live_reg == 2'h0)
      sel_reg <= serial_mode_sel_n;
  end
  // at most one charging behaviour per port
  always_comb
  begin
    excl = 1'b1;
    for (int i = 0; i < 4; i++)
      excl &= $onehot0({low_divider_mode[i], high_divider_mode[i], cdp_mode[i], dcp_mode[i],
        alt_mode[i]});
  end
  // a divider mode meets a DP pull-up
  sequence div_pull;
    (low_divider_mode[0] || high_divider_mode[0]) && dp_pullup_seen[0];
  endsequence
  // power gap: no mode flag shown
  sequence gap_quiet;
    !(low_divider_mode[0] || high_divider_mode[0] || alt_mode[0] || dcp_mode[0] || cdp_mode[0]) [*3];
  endsequence
  chk_ss_disable: assert property (
    live_reg == 2'h3 |-> ds_superspeed_disable == !$past(upstream_superspeed))
    else $error("superspeed disable does not follow upstream speed");
  chk_hs_disable: assert property (
    live_reg == 2'h3 |-> ds_high_speed_disable ==
      !($past(upstream_superspeed) || $past(upstream_high_speed)))
    else $error("high-speed disable does not follow upstream speed");
  chk_serial_sel: assert property (live_reg == 2'h3 |-> smbus_slave_mode == !sel_reg)
    else $error("slave mode differs from the latched serial select");
  chk_div_vbus: assert property (
    upstream_vbus [*5] |=> (low_divider_mode | high_divider_mode) == 4'h0)
    else $error("divider mode shown with upstream connected");
  chk_mode_excl: assert property (excl)
    else $error("two charging behaviours on one port");
  chk_div_gap: assert property (div_pull |=> gap_quiet)
    else $error("divider left without a power gap");
  chk_alt_gap: assert property (alt_mode[0] && dp_pullup_seen[0] |=> gap_quiet)
    else $error("alternate mode left without a power gap");
  chk_div_stay: assert property (
    (!upstream_vbus) [*4] ##0 (high_divider_mode[0] && !dp_pullup_seen[0] && !cfg_wr &&
      !$past(cfg_wr)) |=> high_divider_mode[0])
    else $error("divider mode left with no pull-up");
endmodule // hub_charge_checker

bind hub_port_charging_power_ctrl hub_charge_checker i_hub_charge_checker (.clock(clock),
  .rst(rst), .cfg_wr(cfg_wr), .serial_mode_sel_n(serial_mode_sel_n),
  .upstream_vbus(upstream_vbus), .upstream_superspeed(upstream_superspeed),
  .upstream_high_speed(upstream_high_speed), .dp_pullup_seen(dp_pullup_seen),
  .low_divider_mode(low_divider_mode), .high_divider_mode(high_divider_mode),
  .cdp_mode(cdp_mode), .dcp_mode(dcp_mode), .alt_mode(alt_mode),
  .smbus_slave_mode(smbus_slave_mode), .ds_superspeed_disable(ds_superspeed_disable),
  .ds_high_speed_disable(ds_high_speed_disable));

/* File: dv/tb_hub_port_charging_power_ctrl.sv */
// Purpose: self-checking bench for the charging and power control block
// Assumes: power gap shortened to 4 cycles, straps held over reset release
// Notes: results are noted in a queue and compared by a separate watcher
`timescale 1ns/1ps
module tb_hub_port_charging_power_ctrl;
  localparam logic [7:0] ADDRS [4] = '{8'h05, 8'h06, 8'h0A, 8'h07};
  localparam logic [7:0] MASKS [4] = '{8'h0C, 8'h0F, 8'h33, 8'h00};
  logic clock, rst, cfg_wr, cfg_rd, rd_d, probe, slow, vdat_en, pol, slave_exp;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
  logic auto_charge_pin_n, per_port_power_mgmt_pin_n, ganged_pin, serial_mode_sel_n;
  logic power_polarity_pin, config_memory_present, upstream_vbus, hub_configured;
  logic upstream_superspeed, upstream_high_speed, smbus_slave_mode;
  logic ds_superspeed_disable, ds_high_speed_disable;
  logic [3:0] port_charge_en_pins, host_port_power, dp_pullup_seen, data_detect_voltage_seen;
  logic [3:0] over_current, port_power_enable_out, port_over_current, low_divider_mode;
  logic [3:0] high_divider_mode, cdp_mode, dcp_mode, alt_mode, attached, en;
  logic [30:0] exp, got, q [$];
  logic [31:0] rnd;
  int err_count, n_checks;
  wire [30:0] obs = {ds_superspeed_disable, ds_high_speed_disable, smbus_slave_mode,
    port_over_current, port_power_enable_out, cdp_mode, dcp_mode, high_divider_mode,
    low_divider_mode, alt_mode};
  hub_port_charging_power_ctrl #(.GAP_CYCLES(4)) i_hub_port_charging_power_ctrl (
    .clock(clock), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .port_charge_en_pins(port_charge_en_pins),
    .auto_charge_pin_n(auto_charge_pin_n), .per_port_power_mgmt_pin_n(per_port_power_mgmt_pin_n),
    .ganged_pin(ganged_pin), .serial_mode_sel_n(serial_mode_sel_n),
    .power_polarity_pin(power_polarity_pin), .config_memory_present(config_memory_present),
    .upstream_vbus(upstream_vbus), .hub_configured(hub_configured),
    .upstream_superspeed(upstream_superspeed), .upstream_high_speed(upstream_high_speed),
    .host_port_power(host_port_power), .dp_pullup_seen(dp_pullup_seen),
    .data_detect_voltage_seen(data_detect_voltage_seen), .over_current(over_current),
    .port_power_enable_out(port_power_enable_out), .port_over_current(port_over_current),
    .low_divider_mode(low_divider_mode), .high_divider_mode(high_divider_mode),
    .cdp_mode(cdp_mode), .dcp_mode(dcp_mode), .alt_mode(alt_mode),
    .smbus_slave_mode(smbus_slave_mode), .ds_superspeed_disable(ds_superspeed_disable),
    .ds_high_speed_disable(ds_high_speed_disable));
  charge_device_model i_charge_device_model (.clock(clock), .rst(rst), .attached(attached),
    .slow(slow), .vdat_en(vdat_en), .powered(port_power_enable_out ^ {4{!pol}}),
    .divider_seen(low_divider_mode | high_divider_mode | alt_mode), .dcp_seen(dcp_mode),
    .dp_pullup_seen(dp_pullup_seen), .data_detect_voltage_seen(data_detect_voltage_seen));
  // clock and the read-answer marker
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) rd_d <= cfg_rd;
  // watcher: oldest note against the read data or the status word
  always @(negedge clock)
  begin
    if (rd_d || probe)
    begin
      exp = q.pop_front();
      got = rd_d ? {23'h0, cfg_rdata} : obs;
      n_checks++;
      if (got !== exp)
      begin
        err_count++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  end
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_wr <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back({23'h0, e});
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clock);
    cfg_rd <= 1'b0;
  endtask
  // m is {power, cdp, dcp, high, low, alt}; speed bits follow the current inputs
  task automatic check(input logic [23:0] m, input logic [3:0] poc);
    q.push_back({!upstream_superspeed, !(upstream_superspeed || upstream_high_speed),
      slave_exp, poc, m});
    probe <= 1'b1;
    @(posedge clock);
    probe <= 1'b0;
  endtask
  task automatic wait_on(input logic [30:0] m, input logic [30:0] v);
    int n;
    n = 0;
    while ((obs & m) !== v && n < 200)
    begin
      @(negedge clock);
      n++;
    end
    if (n == 200)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, obs & m, v);
    end
    @(posedge clock);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  // watchdog
  initial
  begin
    #500us;
    err_count++;
    final_report();
  end
  // main sequence
  initial
  begin
    {cfg_wr, cfg_rd, probe, slow, vdat_en, cfg_addr, cfg_wdata} = '0;
    rst = 1'b1;
    {auto_charge_pin_n, per_port_power_mgmt_pin_n, ganged_pin, serial_mode_sel_n} = '0;
    {upstream_vbus, hub_configured, host_port_power, attached, port_charge_en_pins} = '0;
    {power_polarity_pin, config_memory_present, upstream_superspeed, upstream_high_speed} = '1;
    {pol, slave_exp, over_current, err_count, n_checks} = {2'h3, 4'h2, 64'h0};
    rnd = $urandom(32'hA3AD);
    do_reset();
    for (int i = 0; i < 4; i++)
    begin
      rnd = $urandom;
      wr(ADDRS[i], rnd[7:0]);
      rd(ADDRS[i], rnd[7:0] & MASKS[i]);
    end
    wr(8'h05, 8'h00);
    wr(8'h06, 8'h0F);
    wr(8'h0A, 8'h03);
    check(24'hF0F000, 4'h2);
    pol <= 1'b0;
    wr(8'h0A, 8'h02);
    check(24'h00F000, 4'h2);
    pol <= 1'b1;
    wr(8'h0A, 8'h03);
    wr(8'h06, 8'h05);
    check(24'h505000, 4'h2);
    wr(8'h05, 8'h04);
    check(24'h505000, 4'h2);
    wr(8'h06, 8'h00);
    check(24'h000000, 4'hF);
    wr(8'h05, 8'h08);
    check(24'hF00000, 4'h2);
    wr(8'h05, 8'h00);
    wr(8'h06, 8'h0F);
    wr(8'h0A, 8'h11);
    {upstream_vbus, hub_configured, host_port_power} <= 6'h3F;
    for (int k = 0; k < 4; k++)
    begin
      {upstream_superspeed, upstream_high_speed} <= k[1:0];
      repeat (6) @(posedge clock);
      check(24'hFF0000, 4'h2);
    end
    {upstream_vbus, hub_configured, host_port_power} <= 6'h00;
    {upstream_superspeed, upstream_high_speed} <= 2'h3;
    wr(8'h06, 8'h01);
    wr(8'h0A, 8'h01);
    repeat (4) @(posedge clock);
    check(24'h100010, 4'h2);
    wr(8'h0A, 8'h11);
    repeat (8) @(posedge clock);
    check(24'h100100, 4'h2);
    attached <= 4'h1;
    wait_on(31'h100000, 31'h0);
    check(24'h000000, 4'h2);
    wait_on(31'h1000, 31'h1000);
    check(24'h101000, 4'h2);
    vdat_en <= 1'b1;
    wait_on(31'h100, 31'h100);
    check(24'h100100, 4'h2);
    slow <= 1'b1;
    wr(8'h0A, 8'h31);
    wait_on(31'h1, 31'h1);
    check(24'h100001, 4'h2);
    vdat_en <= 1'b0;
    wait_on(31'h1000, 31'h1000);
    check(24'h101000, 4'h2);
    {upstream_vbus, hub_configured, host_port_power} <= 6'h31;
    repeat (8) @(posedge clock);
    check(24'h110000, 4'h2);
    {upstream_vbus, hub_configured, host_port_power, attached} <= 10'h0;
    {serial_mode_sel_n, config_memory_present, slave_exp} <= 3'h4;
    rnd = $urandom;
    en = rnd[3:0];
    port_charge_en_pins <= en;
    do_reset();
    port_charge_en_pins <= ~en;
    repeat (6) @(posedge clock);
    check({en, 8'h00, en, 8'h00}, 4'h2);
    final_report();
  end
endmodule // tb_hub_port_charging_power_ctrl

/* File: rtl/hub_charge_pkg.sv */
// Purpose: constants and types for the hub port charging and power control block
// Assumes: 40 MHz core clock, four downstream ports
// Notes: register bit positions and timing counts live here only
//
// Summary of operation
// [R1] per-port charging enable field, four bits
// [R2] cleared enable means no charging support
// [R3] charging downstream port needs vbus, configuration, port power
// [R4] unconnected, non-automatic: hold dedicated charging mode
// [R5] divider modes only unconnected with automatic
// [R6] unconnected and enabled: assert port power
// [R7] automatic starts in highest divider, waits pull-up; register mode starts in low divider while the high divider enable is clear
// [R8] divider pull-up: power gap, alternate or dedicated
// [R9] alternate pull-up: power gap, then dedicated
// [R10] dedicated pull-up or data-detect: gap, back to divider
// [R11] cycle until upstream connects, then leave
// [R12] divider mode drives fixed level on data lines
// [R13] register mode: auto bit, divider select choose modes
// [R14] pin mode: strap enables, high divider alternation
// [R15] charging forces per-port power management
// [R16] power switching and ganged select from power register
// [R17] power enable output polarity from mode register
// [R18] slow upstream disables downstream superspeed
// [R19] full/low-speed upstream also disables high-speed
// [R20] straps latched at reset release
// [R21] serial mode pin selects memory master or slave
// [R22] power gap length is a clock count
// [R23] upstream vbus synchronised before use
package hub_charge_pkg;

  localparam int NUM_PORTS = 4;

  // register offsets
  localparam logic [7:0] POWER_SWITCH_CONFIG_ADDR = 8'h05;
  localparam logic [7:0] PORT_CHARGING_ENABLE_ADDR = 8'h06;
  localparam logic [7:0] CHARGING_MODE_CONFIG_ADDR = 8'h0A;

  // power_switch_config fields
  localparam int PER_PORT_POWER_MGMT_N_BIT = 3;
  localparam int GANGED_BIT = 2;
  localparam logic [7:0] POWER_SWITCH_CONFIG_MASK = 8'h0C;

  // port_charging_enable fields
  localparam logic [7:0] PORT_CHARGING_ENABLE_MASK = 8'h0F;

  // charging_mode_config fields
  localparam int POWER_ENABLE_POLARITY_BIT = 0;
  localparam int AUTO_CHARGE_SEL_N_BIT = 1;
  localparam int HIGH_DIVIDER_EN_BIT = 4;
  localparam int ALT_CHARGE_EN_BIT = 5;
  localparam logic [7:0] CHARGING_MODE_CONFIG_MASK = 8'h33;

  // register values during reset, before the strap load
  localparam logic [7:0] POWER_SWITCH_CONFIG_RESET = 8'h08;
  localparam logic [7:0] CHARGING_MODE_CONFIG_RESET = 8'h02;

  // power gap between charging modes
  localparam int CLOCK_MHZ = 40;
  localparam int POWER_GAP_US = 100;
  localparam int POWER_GAP_CYCLES = POWER_GAP_US * CLOCK_MHZ;
  localparam int GAP_COUNT_WIDTH = 16;

  // per-port charging behaviour
  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_CDP,
    MODE_DCP,
    MODE_LOW_DIV,
    MODE_HIGH_DIV,
    MODE_ALT,
    MODE_AUTO_DCP,
    MODE_GAP
  } charge_mode_t;

endpackage

/* File: rtl/hub_port_charging_power_ctrl.sv */
// Purpose: per-port charging mode sequencing and port power switch control
// Assumes: inputs other than upstream_vbus are synchronous to clock
// Notes: register file is loaded from the straps right after reset release
//   gap length is the GAP_CYCLES parameter
`timescale 1ns/1ps
module hub_port_charging_power_ctrl #(
  parameter int GAP_CYCLES = hub_charge_pkg::POWER_GAP_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // configuration register access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // strap pins sampled at reset release; config_memory_present is read live
  input wire logic [3:0] port_charge_en_pins,
  input wire logic auto_charge_pin_n,
  input wire logic per_port_power_mgmt_pin_n,
  input wire logic ganged_pin,
  input wire logic serial_mode_sel_n,
  input wire logic power_polarity_pin,
  input wire logic config_memory_present,
  // upstream status
  input wire logic upstream_vbus,
  input wire logic hub_configured,
  input wire logic upstream_superspeed,
  input wire logic upstream_high_speed,
  // downstream port status
  input wire logic [3:0] host_port_power,
  input wire logic [3:0] dp_pullup_seen,
  input wire logic [3:0] data_detect_voltage_seen,
  input wire logic [3:0] over_current,
  // power switch outputs
  output logic [3:0] port_power_enable_out,
  output logic [3:0] port_over_current,
  // charging mode flags
  output logic [3:0] low_divider_mode,
  output logic [3:0] high_divider_mode,
  output logic [3:0] cdp_mode,
  output logic [3:0] dcp_mode,
  output logic [3:0] alt_mode,
  // serial mode and speed limits
  output logic smbus_slave_mode,
  output logic ds_superspeed_disable,
  output logic ds_high_speed_disable
);

  // whole block state, registered as one word
  typedef struct packed {
    // configuration registers and read data
    logic [7:0] power_switch_config;
    logic [7:0] port_charging_enable;
    logic [7:0] charging_mode_config;
    logic [7:0] rdata;
    // strap copies and vbus synchroniser
    logic in_reset;
    logic [3:0] strap_charge_en;
    logic strap_auto_n;
    logic strap_serial_n;
    logic vbus_meta;
    logic vbus_sync;
    // per-port sequencer state
    hub_charge_pkg::charge_mode_t [3:0] mode;
    hub_charge_pkg::charge_mode_t [3:0] after_gap;
    logic [3:0][hub_charge_pkg::GAP_COUNT_WIDTH-1:0] gap_cnt;
    // registered outputs
    logic [3:0] power_out;
    logic [3:0] oc_out;
    logic [3:0] low_div;
    logic [3:0] high_div;
    logic [3:0] cdp;
    logic [3:0] dcp;
    logic [3:0] alt;
    logic slave_mode;
    logic ss_dis;
    logic hs_dis;
  } state_t;

  // gap counter counts down from here to zero
  localparam logic [hub_charge_pkg::GAP_COUNT_WIDTH-1:0] GAP_LOAD =
    hub_charge_pkg::GAP_COUNT_WIDTH'(GAP_CYCLES - 1);

  // registered state and its next value
  state_t state_reg;
  state_t state_next;

  // next-state logic for the whole block
  always_comb
  begin
    logic pin_mode;
    logic [3:0] charge_en;
    logic auto_on;
    logic alt_en;
    logic polarity;
    logic ganged;
    logic switching_on;
    logic [3:0] logical_power;
    hub_charge_pkg::charge_mode_t divider;
    // defaults, so every path assigns
    pin_mode = 1'b0;
    charge_en = 4'h0;
    auto_on = 1'b0;
    alt_en = 1'b0;
    polarity = 1'b0;
    ganged = 1'b0;
    switching_on = 1'b0;
    logical_power = 4'h0;
    divider = hub_charge_pkg::MODE_HIGH_DIV;
    // hold all state unless changed below
    state_next = state_reg;

    // two-stage synchroniser for upstream vbus
    state_next.vbus_meta = upstream_vbus; // [R23]
    state_next.vbus_sync = state_reg.vbus_meta; // [R23]

    // register writes, then strap load on the first cycle after reset
    if (cfg_wr)
    begin
      // undefined bits are masked off and read as zero
      case (cfg_addr)
        hub_charge_pkg::POWER_SWITCH_CONFIG_ADDR:
          state_next.power_switch_config = cfg_wdata & hub_charge_pkg::POWER_SWITCH_CONFIG_MASK;
        hub_charge_pkg::PORT_CHARGING_ENABLE_ADDR:
          state_next.port_charging_enable = cfg_wdata & hub_charge_pkg::PORT_CHARGING_ENABLE_MASK;
        hub_charge_pkg::CHARGING_MODE_CONFIG_ADDR:
          state_next.charging_mode_config = cfg_wdata & hub_charge_pkg::CHARGING_MODE_CONFIG_MASK;
        default:
          state_next.rdata = state_next.rdata; // unmapped writes ignored
      endcase
    end
    // a write in this same cycle loses to the strap load
    if (state_reg.in_reset)
    begin
      state_next.in_reset = 1'b0;
      state_next.strap_charge_en = port_charge_en_pins; // [R20]
      state_next.strap_auto_n = auto_charge_pin_n; // [R20]
      state_next.strap_serial_n = serial_mode_sel_n; // [R20] [R21]
      // straps seed the registers; writes may change them later
      state_next.port_charging_enable = {4'h0, port_charge_en_pins}; // [R20]
      state_next.power_switch_config = 8'h00;
      state_next.power_switch_config[hub_charge_pkg::PER_PORT_POWER_MGMT_N_BIT] =
        per_port_power_mgmt_pin_n; // [R20]
      state_next.power_switch_config[hub_charge_pkg::GANGED_BIT] = ganged_pin; // [R20]
      state_next.charging_mode_config = 8'h00;
      state_next.charging_mode_config[hub_charge_pkg::AUTO_CHARGE_SEL_N_BIT] =
        auto_charge_pin_n; // [R20]
      state_next.charging_mode_config[hub_charge_pkg::POWER_ENABLE_POLARITY_BIT] =
        power_polarity_pin; // [R20]
    end

    // register reads, one cycle latency, unmapped reads give zero
    if (cfg_rd)
    begin
      // a read and write together return the old value
      case (cfg_addr)
        hub_charge_pkg::POWER_SWITCH_CONFIG_ADDR:
          state_next.rdata = state_reg.power_switch_config;
        hub_charge_pkg::PORT_CHARGING_ENABLE_ADDR:
          state_next.rdata = state_reg.port_charging_enable;
        hub_charge_pkg::CHARGING_MODE_CONFIG_ADDR:
          state_next.rdata = state_reg.charging_mode_config;
        default:
          state_next.rdata = 8'h00;
      endcase
    end

    // effective configuration: straps without memory in master mode, else registers
    state_next.slave_mode = ~state_reg.strap_serial_n; // [R21]
    pin_mode = state_reg.strap_serial_n & ~config_memory_present; // [R14]
    // pin mode: no alternate mode, high divider only
    if (pin_mode)
    begin
      charge_en = state_reg.strap_charge_en; // [R14]
      auto_on = ~state_reg.strap_auto_n; // [R14]
      divider = hub_charge_pkg::MODE_HIGH_DIV; // [R14]
      alt_en = 1'b0;
    end
    else
    begin
      charge_en = state_reg.port_charging_enable[3:0]; // [R1]
      auto_on = ~state_reg.charging_mode_config[hub_charge_pkg::AUTO_CHARGE_SEL_N_BIT]; // [R13]
      divider = state_reg.charging_mode_config[hub_charge_pkg::HIGH_DIVIDER_EN_BIT] ?
        hub_charge_pkg::MODE_HIGH_DIV : hub_charge_pkg::MODE_LOW_DIV; // [R13]
      alt_en = state_reg.charging_mode_config[hub_charge_pkg::ALT_CHARGE_EN_BIT];
    end
    // polarity bit serves both configuration sources
    polarity = state_reg.charging_mode_config[hub_charge_pkg::POWER_ENABLE_POLARITY_BIT];
    // charging forces per-port full power management
    ganged = state_reg.power_switch_config[hub_charge_pkg::GANGED_BIT] & ~(|charge_en); // [R15]
    switching_on = ~state_reg.power_switch_config[hub_charge_pkg::PER_PORT_POWER_MGMT_N_BIT]
      | (|charge_en); // [R15] [R16]

    // per-port charging mode sequencer
    for (int i = 0; i < hub_charge_pkg::NUM_PORTS; i++)
    begin
      // disabled ports ignore vbus and automatic settings
      if (!charge_en[i])
      begin
        state_next.mode[i] = hub_charge_pkg::MODE_OFF; // [R2]
      end
      else if (state_reg.vbus_sync)
      begin
        // upstream present: leave the automatic sequence
        state_next.mode[i] = (hub_configured && host_port_power[i]) ?
          hub_charge_pkg::MODE_CDP : hub_charge_pkg::MODE_OFF; // [R3] [R11]
      end
      else if (!auto_on)
      begin
        state_next.mode[i] = hub_charge_pkg::MODE_DCP; // [R4] [R5]
      end
      else
      begin
        case (state_reg.mode[i])
          hub_charge_pkg::MODE_LOW_DIV, hub_charge_pkg::MODE_HIGH_DIV:
          begin
            // stay in the divider until DP is pulled up
            if (dp_pullup_seen[i])
            begin
              state_next.mode[i] = hub_charge_pkg::MODE_GAP; // [R8]
              state_next.gap_cnt[i] = GAP_LOAD; // [R22]
              state_next.after_gap[i] = alt_en ?
                hub_charge_pkg::MODE_ALT : hub_charge_pkg::MODE_AUTO_DCP; // [R8]
            end
            else
            begin
              state_next.mode[i] = divider; // [R7]
            end
          end
          hub_charge_pkg::MODE_ALT:
          begin
            // alternate mode also waits for a DP pull-up
            if (dp_pullup_seen[i])
            begin
              state_next.mode[i] = hub_charge_pkg::MODE_GAP; // [R9]
              state_next.gap_cnt[i] = GAP_LOAD; // [R22]
              state_next.after_gap[i] = hub_charge_pkg::MODE_AUTO_DCP; // [R9]
            end
          end
          hub_charge_pkg::MODE_AUTO_DCP:
          begin
            // pull-up or data-detect voltage ends dedicated mode
            if (dp_pullup_seen[i] || data_detect_voltage_seen[i])
            begin
              state_next.mode[i] = hub_charge_pkg::MODE_GAP; // [R10]
              state_next.gap_cnt[i] = GAP_LOAD; // [R22]
              state_next.after_gap[i] = divider; // [R10] [R11]
            end
          end
          hub_charge_pkg::MODE_GAP:
          begin
            // power held off until the gap count runs out
            // loaded with one less than the gap length
            if (state_reg.gap_cnt[i] == '0)
            begin
              state_next.mode[i] = state_reg.after_gap[i]; // [R22]
            end
            else
            begin
              state_next.gap_cnt[i] = state_reg.gap_cnt[i] - 1'b1; // [R22]
            end
          end
          default:
          begin
            // entering automatic operation starts in the selected divider: high in pin mode, else high or low per the high divider enable
            state_next.mode[i] = divider; // [R5] [R7]
          end
        endcase
      end
    end

    // logical power per port, then polarity
    for (int i = 0; i < hub_charge_pkg::NUM_PORTS; i++)
    begin
      if (charge_en[i])
      begin
        // charging ports are off only when off or in a gap
        logical_power[i] = (state_next.mode[i] != hub_charge_pkg::MODE_OFF) &&
          (state_next.mode[i] != hub_charge_pkg::MODE_GAP); // [R6] [R8] [R9] [R10]
      end
      else if (!switching_on)
      begin
        logical_power[i] = 1'b1; // no power switching: supply left on
      end
      else if (ganged)
      begin
        logical_power[i] = |host_port_power; // [R16]
      end
      else
      begin
        logical_power[i] = host_port_power[i]; // [R16]
      end
      // over-current follows the same ganged choice
      state_next.oc_out[i] = ganged ? |over_current : over_current[i]; // [R16]
      state_next.power_out[i] = polarity ? logical_power[i] : ~logical_power[i]; // [R17]
      // flags decode the next mode, aligned with power
      state_next.low_div[i] = state_next.mode[i] == hub_charge_pkg::MODE_LOW_DIV; // [R12]
      state_next.high_div[i] = state_next.mode[i] == hub_charge_pkg::MODE_HIGH_DIV; // [R12]
      state_next.cdp[i] = state_next.mode[i] == hub_charge_pkg::MODE_CDP; // [R3]
      state_next.dcp[i] = (state_next.mode[i] == hub_charge_pkg::MODE_DCP) ||
        (state_next.mode[i] == hub_charge_pkg::MODE_AUTO_DCP); // [R4]
      state_next.alt[i] = state_next.mode[i] == hub_charge_pkg::MODE_ALT; // [R9]
    end

    // downstream speed limits follow the upstream connection
    // registered, one cycle behind the speed inputs
    state_next.ss_dis = ~upstream_superspeed; // [R18]
    state_next.hs_dis = ~upstream_superspeed & ~upstream_high_speed; // [R19]
  end

  // state register
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      // outputs low; straps load on the first edge after release
      state_reg <= '0;
      state_reg.in_reset <= 1'b1;
      state_reg.strap_serial_n <= 1'b1;
      state_reg.power_switch_config <= hub_charge_pkg::POWER_SWITCH_CONFIG_RESET;
      state_reg.charging_mode_config <= hub_charge_pkg::CHARGING_MODE_CONFIG_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // outputs come straight from the state register
  // so no output glitches on input changes
  assign cfg_rdata = state_reg.rdata;
  assign port_power_enable_out = state_reg.power_out;
  assign port_over_current = state_reg.oc_out;
  assign low_divider_mode = state_reg.low_div;
  assign high_divider_mode = state_reg.high_div;
  assign cdp_mode = state_reg.cdp;
  assign dcp_mode = state_reg.dcp;
  assign alt_mode = state_reg.alt;
  assign smbus_slave_mode = state_reg.slave_mode;
  assign ds_superspeed_disable = state_reg.ss_dis;
  assign ds_high_speed_disable = state_reg.hs_dis;

endmodule // hub_port_charging_power_ctrl
